//--- include/tlv_pkg.sv
// tlv_pkg: register map, source numbering and vector constants of the
// two-level vectored interrupt controller.
// assumes a 32-bit AHB-Lite bus with one aligned word per register.
package tlv_pkg;
	localparam int NUM_SRC = 22;
	localparam int IDX_W = 5;
	// ==========================================================
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_BASE_EN = 8'hA8;
	localparam logic [7:0] IDX_PORT1_FLAGS = 8'hAD;
	localparam logic [7:0] IDX_TIMER_FLAGS = 8'h88;
	localparam logic [7:0] IDX_BASE_PRIO = 8'hB8;
	localparam logic [7:0] IDX_EXT_EN_A = 8'hE6;
	localparam logic [7:0] IDX_EXT_EN_B = 8'hE7;
	localparam logic [7:0] IDX_PRIO_A = 8'hF6;
	localparam logic [7:0] IDX_PRIO_B = 8'hF7;
	localparam logic [7:0] IDX_STATUS = 8'hF0;
	// ==========================================================
	// reset values
	localparam logic [7:0] RST_REG8 = 8'h00;
	localparam logic [15:0] VEC_RESET = 16'h0000;
	// ==========================================================
	// vectors and source numbers
	localparam logic [15:0] VEC_FIRST = 16'h0003;
	localparam int VEC_STEP_SHIFT = 3;
	localparam logic [15:0] VEC_LAST = 16'h00AB;
	localparam logic [IDX_W-1:0] SRC_EXT0 = 5'd0;
	localparam logic [IDX_W-1:0] SRC_TIMER0 = 5'd1;
	localparam logic [IDX_W-1:0] SRC_EXT1 = 5'd2;
	localparam logic [IDX_W-1:0] SRC_TIMER1 = 5'd3;
	localparam int SRC_UNUSED = 20;
	// ==========================================================
	// field positions
	localparam int BIT_GLOBAL_EN = 7;
	localparam int BIT_TIMER0 = 5;
	localparam int BIT_TIMER1 = 7;
	localparam int BIT_PRIO_B_RSVD = 6;
	localparam int BIT_PORT1_LO = 4;
	// ==========================================================
	// latency figures in system clocks, kept for the core side
	localparam int DETECT_CYCLES = 1;
	localparam int CALL_CYCLES = 4;
	localparam int MIN_RESPONSE = DETECT_CYCLES + CALL_CYCLES;
	localparam int MAX_RESPONSE = 18;
endpackage : tlv_pkg

//--- src/tlv_irq_ctrl.sv
// tlv_irq_ctrl: collects the source flags, arbitrates two priority levels
// with a fixed tie order and presents one vector to the processor core.
// assumes the core pulses ack when it starts the call, return_from_irq when a return
// completes and instr_done after each other instruction; AHB-Lite slave.
// Function
// [R1] each source has a fixed vector, 0x0003 upward in steps of eight to 0x00AB
// [R2] equal level ties go to the lowest fixed order number
// [R3] counter array request is overflow OR any capture flag; UART is rx OR tx
// [R4] timer 2 request is overflow OR external flag
// [R5] every source has a priority bit, all reset to low
// [R6] high preempts running low routine; nothing preempts a high routine
// [R7] higher level request is served first among simultaneous requests
// [R8] pending requests are sampled and resolved every clock
// [R9] one cycle detect, then four cycle call by the core
// [R10] after a return one more instruction runs before the next call
// [R11] worst case response is eighteen clocks through return and divide
// [R12] requests at or below the running level wait for return plus one instruction
// [R13] priority register A maps comparator, counter array, window, two-wire, serial
// [R14] priority register B maps crystal, external 7..4, conversion done, timer 3
// [R15] bit 6 of priority register B reads zero
// [R16] external 4..7 vectors 0x0083..0x009B, flags in port 1 edge flags bits 4..7
// [R17] comparator falling and rising requests have their own vectors
// [R18] conversion done vectors to 0x007B, converter window to 0x0043
// [R19] crystal ready uses its flag, vector 0x00AB, enable bit 7 of enable B
// [R20] falling edge on port 1 pin sets matching external pending flag
// [R21] timer 0 and 1 flags clear by software or on vectoring
// [R22] active levels tracked, one level released per return
`timescale 1ns/10ps
module tlv_irq_ctrl (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic ext0_flag,
	input wire logic ext1_flag,
	input wire logic timer0_overflow_set,
	input wire logic timer1_overflow_set,
	input wire logic uart_rx_flag,
	input wire logic uart_tx_flag,
	input wire logic timer2_overflow_flag,
	input wire logic timer2_external_flag,
	input wire logic serial_periph_flag,
	input wire logic twowire_flag,
	input wire logic conv_window_flag,
	input wire logic counter_array_overflow_flag,
	input wire logic [4:0] capture_module_flags,
	input wire logic [1:0] cmp_fall_flags,
	input wire logic [1:0] cmp_rise_flags,
	input wire logic timer3_flag,
	input wire logic conv_done_flag,
	input wire logic xtal_valid_flag,
	input wire logic [3:0] port1_pins,
	input wire logic core_irq_ack,
	input wire logic core_return_from_irq,
	input wire logic core_instr_done,
	output logic core_irq_req,
	output logic [15:0] core_irq_vector,
	output logic core_irq_level,
	output logic timer0_overflow_flag,
	output logic timer1_overflow_flag
);
	localparam int N = tlv_pkg::NUM_SRC;
	localparam int W = tlv_pkg::IDX_W;

	// ==========================================================
	// registers
	logic [7:0] base_irq_enable;
	logic [7:0] base_irq_priority;
	logic [7:0] ext_irq_enable_a;
	logic [7:0] ext_irq_enable_b;
	logic [7:0] ext_irq_priority_a;
	logic [7:0] ext_irq_priority_b;
	logic [3:0] port1_edge_flags;
	logic active_low;
	logic active_high;
	logic hold_after_return_from_irq;
	logic [W-1:0] req_idx;

	// ==========================================================
	// AHB-Lite slave, zero wait states
	logic dp_write;
	logic dp_valid;
	logic [7:0] dp_idx;
	wire addr_phase = hsel && htrans[1] && hready;
	wire [7:0] ap_idx = haddr[9:2];
	wire wr_now = dp_valid && dp_write;
	wire wr_base_en = wr_now && (dp_idx == tlv_pkg::IDX_BASE_EN);
	wire wr_base_prio = wr_now && (dp_idx == tlv_pkg::IDX_BASE_PRIO);
	wire wr_en_a = wr_now && (dp_idx == tlv_pkg::IDX_EXT_EN_A);
	wire wr_en_b = wr_now && (dp_idx == tlv_pkg::IDX_EXT_EN_B);
	wire wr_prio_a = wr_now && (dp_idx == tlv_pkg::IDX_PRIO_A);
	wire wr_prio_b = wr_now && (dp_idx == tlv_pkg::IDX_PRIO_B);
	wire wr_port1 = wr_now && (dp_idx == tlv_pkg::IDX_PORT1_FLAGS);
	wire wr_timers = wr_now && (dp_idx == tlv_pkg::IDX_TIMER_FLAGS);

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_idx <= tlv_pkg::RST_REG8;
		end else begin
			dp_valid <= addr_phase;
			dp_write <= hwrite;
			dp_idx <= ap_idx;
		end
	end

	// ==========================================================
	// port 1 pins: three flops, a level counts once stages two and three agree
	logic [3:0] p1_s1;
	logic [3:0] p1_s2;
	logic [3:0] p1_s3;
	logic [3:0] p1_level;
	wire [3:0] p1_agree = ~(p1_s2 ^ p1_s3);
	wire [3:0] p1_fall = p1_level & p1_agree & ~p1_s3;
	wire [3:0] p1_next_level = (p1_level & ~p1_agree) | (p1_s3 & p1_agree);
	wire [3:0] p1_clear = wr_port1 ? hwdata[7:4] : 4'h0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			p1_s1 <= 4'hF;
			p1_s2 <= 4'hF;
			p1_s3 <= 4'hF;
			p1_level <= 4'hF;
			port1_edge_flags <= 4'h0;
		end else begin
			p1_s1 <= port1_pins;
			p1_s2 <= p1_s1;
			p1_s3 <= p1_s2;
			p1_level <= p1_next_level;
			// a new edge wins over a software clear in the same cycle
			port1_edge_flags <= (port1_edge_flags & ~p1_clear) | p1_fall; // R20
		end
	end

	// ==========================================================
	// pending, enable and priority vectors in fixed order
	logic [N-1:0] pending;
	logic [N-1:0] enabled;
	logic [N-1:0] level_hi;
	assign pending[0] = ext0_flag;
	assign pending[1] = timer0_overflow_flag;
	assign pending[2] = ext1_flag;
	assign pending[3] = timer1_overflow_flag;
	assign pending[4] = uart_rx_flag | uart_tx_flag; // R3
	assign pending[5] = timer2_overflow_flag | timer2_external_flag; // R4
	assign pending[6] = serial_periph_flag;
	assign pending[7] = twowire_flag;
	assign pending[8] = conv_window_flag; // R18
	assign pending[9] = counter_array_overflow_flag | (|capture_module_flags); // R3
	assign pending[10] = cmp_fall_flags[0]; // R17
	assign pending[11] = cmp_rise_flags[0]; // R17
	assign pending[12] = cmp_fall_flags[1];
	assign pending[13] = cmp_rise_flags[1];
	assign pending[14] = timer3_flag;
	assign pending[15] = conv_done_flag; // R18
	assign pending[19:16] = port1_edge_flags; // R16
	assign pending[20] = 1'b0;
	assign pending[21] = xtal_valid_flag; // R19
	assign enabled = {ext_irq_enable_b[7], 1'b0, ext_irq_enable_b[5:0], ext_irq_enable_a,
		base_irq_enable[5:0]}; // R19
	assign level_hi = {ext_irq_priority_b[7], 1'b0, ext_irq_priority_b[5:0], ext_irq_priority_a,
		base_irq_priority[5:0]}; // R13 R14 R5

	// ==========================================================
	// arbitration, resolved every cycle
	wire [N-1:0] cand = pending & enabled & {N{base_irq_enable[tlv_pkg::BIT_GLOBAL_EN]}}; // R8
	wire [N-1:0] cand_hi = cand & level_hi;
	wire [N-1:0] cand_pick = (|cand_hi) ? cand_hi : cand; // R7
	wire win_valid = |cand;
	wire win_hi = |cand_hi;
	logic [W-1:0] win_idx;

	always_comb begin
		win_idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (cand_pick[i]) begin
				win_idx = W'(i); // R2
			end
		end
	end

	// low may start only when idle; high only when no high routine runs
	wire level_ok = win_hi ? !active_high : (!active_high && !active_low); // R6 R12
	// a return in flight blocks too, so the request never lands before the one instruction
	wire can_take = win_valid && level_ok && !hold_after_return_from_irq && !core_return_from_irq; // R10 R12
	wire next_req = can_take && !core_irq_ack;
	wire [15:0] next_vector = tlv_pkg::VEC_FIRST + (16'(win_idx) << tlv_pkg::VEC_STEP_SHIFT); // R1

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_irq_req <= 1'b0;
			core_irq_vector <= tlv_pkg::VEC_RESET; // R1
			core_irq_level <= 1'b0;
			req_idx <= '0;
		end else begin
			core_irq_req <= next_req; // R9
			core_irq_vector <= next_vector;
			core_irq_level <= win_hi;
			req_idx <= win_idx;
		end
	end

	// ==========================================================
	// nesting state; the core owns the call and return timing
	wire take = core_irq_ack && core_irq_req;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			active_low <= 1'b0;
			active_high <= 1'b0;
			hold_after_return_from_irq <= 1'b0;
		end else begin
			if (take && core_irq_level) begin
				active_high <= 1'b1;
			end else if (core_return_from_irq && active_high) begin
				active_high <= 1'b0; // R22
			end
			if (take && !core_irq_level) begin
				active_low <= 1'b1;
			end else if (core_return_from_irq && !active_high) begin
				active_low <= 1'b0; // R22
			end
			// return sets, one following instruction clears; set wins
			if (core_return_from_irq) begin
				hold_after_return_from_irq <= 1'b1; // R10
			end else if (core_instr_done) begin
				hold_after_return_from_irq <= 1'b0; // R11
			end
		end
	end

	// ==========================================================
	// timer 0/1 flags, cleared by write-one or by vectoring
	wire t0_vec = take && (req_idx == tlv_pkg::SRC_TIMER0);
	wire t1_vec = take && (req_idx == tlv_pkg::SRC_TIMER1);
	wire t0_sw = wr_timers && hwdata[tlv_pkg::BIT_TIMER0];
	wire t1_sw = wr_timers && hwdata[tlv_pkg::BIT_TIMER1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer0_overflow_flag <= 1'b0;
			timer1_overflow_flag <= 1'b0;
		end else begin
			timer0_overflow_flag <= timer0_overflow_set | (timer0_overflow_flag & ~(t0_vec | t0_sw)); // R21
			timer1_overflow_flag <= timer1_overflow_set | (timer1_overflow_flag & ~(t1_vec | t1_sw)); // R21
		end
	end

	// ==========================================================
	// configuration registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			base_irq_enable <= tlv_pkg::RST_REG8;
			base_irq_priority <= tlv_pkg::RST_REG8; // R5
			ext_irq_enable_a <= tlv_pkg::RST_REG8;
			ext_irq_enable_b <= tlv_pkg::RST_REG8;
			ext_irq_priority_a <= tlv_pkg::RST_REG8; // R5
			ext_irq_priority_b <= tlv_pkg::RST_REG8; // R5
		end else begin
			if (wr_base_en) base_irq_enable <= hwdata[7:0];
			if (wr_base_prio) base_irq_priority <= {2'b00, hwdata[5:0]};
			if (wr_en_a) ext_irq_enable_a <= hwdata[7:0];
			if (wr_en_b) ext_irq_enable_b <= {hwdata[7], 1'b0, hwdata[5:0]};
			if (wr_prio_a) ext_irq_priority_a <= hwdata[7:0]; // R13
			if (wr_prio_b) ext_irq_priority_b <= {hwdata[7], 1'b0, hwdata[5:0]}; // R14 R15
		end
	end

	// ==========================================================
	// read mux, registered at the address phase
	wire [7:0] status = {core_irq_req, hold_after_return_from_irq, active_high, active_low, 4'h0};
	logic [7:0] rd_sel;

	always_comb begin
		case (ap_idx)
			tlv_pkg::IDX_BASE_EN: rd_sel = base_irq_enable;
			tlv_pkg::IDX_BASE_PRIO: rd_sel = base_irq_priority;
			tlv_pkg::IDX_EXT_EN_A: rd_sel = ext_irq_enable_a;
			tlv_pkg::IDX_EXT_EN_B: rd_sel = ext_irq_enable_b;
			tlv_pkg::IDX_PRIO_A: rd_sel = ext_irq_priority_a;
			tlv_pkg::IDX_PRIO_B: rd_sel = ext_irq_priority_b & 8'hBF; // R15
			tlv_pkg::IDX_PORT1_FLAGS: rd_sel = {port1_edge_flags, 4'h0};
			tlv_pkg::IDX_TIMER_FLAGS: rd_sel = {timer1_overflow_flag, 1'b0, timer0_overflow_flag, 5'h00};
			tlv_pkg::IDX_STATUS: rd_sel = status | {3'b000, req_idx};
			default: rd_sel = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			hrdata <= {24'h00_0000, rd_sel};
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	wire [N-1:0] lower_mask = N'((22'h00_0001 << win_idx) - 22'h00_0001);

	sequence s_return_from_irq;
		core_return_from_irq;
	endsequence
	sequence s_blocked_one;
		hold_after_return_from_irq && !core_irq_req;
	endsequence

	a_vec_format: assert property (core_irq_req |-> core_irq_vector[2:0] == 3'b011
		&& core_irq_vector <= tlv_pkg::VEC_LAST) else $error("vector off grid"); // R1
	a_tie_lowest: assert property (win_valid |-> (cand_pick & lower_mask) == '0)
		else $error("tie not lowest order"); // R2
	a_hi_first: assert property (win_hi |=> core_irq_level) else $error("low level beat high"); // R7
	a_no_preempt_hi: assert property (active_high |-> ##1 !core_irq_req) else $error("high preempted"); // R6
	a_detect_one: assert property (can_take && !core_irq_ack |=> core_irq_req
		&& core_irq_vector == $past(next_vector)) else $error("request not one cycle after detect"); // R9
	a_return_from_irq_hold: assert property (s_return_from_irq |=> s_blocked_one) else $error("request right after return"); // R10
	a_timer_vec: assert property (t0_vec && !timer0_overflow_set |=> !timer0_overflow_flag)
		else $error("timer0 flag kept after vectoring"); // R21
	a_edge_set: assert property (p1_fall[0] |=> port1_edge_flags[0]) else $error("edge flag missed"); // R20
	a_rsvd_zero: assert property (ext_irq_priority_b[tlv_pkg::BIT_PRIO_B_RSVD] == 1'b0)
		else $error("reserved priority bit set"); // R15
	a_pca_or: assert property (counter_array_overflow_flag && enabled[9] && base_irq_enable[7]
		|-> cand[9]) else $error("counter array request lost"); // R3
	a_level_release: assert property (core_return_from_irq && active_high && !take |=> !active_high && $stable(active_low))
		else $error("return released wrong level"); // R22
	a_wait_equal: assert property (active_low && !win_hi |-> ##1 !core_irq_req)
		else $error("equal level taken while running"); // R12
endmodule : tlv_irq_ctrl

//--- verif/tlv_core_model.sv
// tlv_core_model: behavioural processor core facing the interrupt controller.
// assumes one clock and reset shared with the controller; the bench steers it.
`timescale 1ns/10ps
module tlv_core_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic core_irq_req,
	input wire logic en_ack,
	input wire logic do_return_from_irq,
	input wire logic [3:0] instr_gap,
	output logic core_irq_ack,
	output logic core_return_from_irq,
	output logic core_instr_done
);
	logic [3:0] gap_cnt;
	logic gap_run;
	// ==========================================================
	// call, return and the one instruction that follows a return
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_irq_ack <= 1'b0;
			core_return_from_irq <= 1'b0;
			core_instr_done <= 1'b0;
			gap_cnt <= 4'h0;
			gap_run <= 1'b0;
		end else begin
			// no second ack while the first is still in flight
			core_irq_ack <= en_ack && core_irq_req && !core_irq_ack;
			core_return_from_irq <= do_return_from_irq;
			core_instr_done <= gap_run && gap_cnt == 4'h0;
			if (core_return_from_irq) begin
				gap_run <= 1'b1;
				gap_cnt <= instr_gap;
			end else if (gap_run && gap_cnt == 4'h0) begin
				gap_run <= 1'b0;
			end else if (gap_run) begin
				gap_cnt <= gap_cnt - 4'h1;
			end
		end
	end
endmodule : tlv_core_model

//--- verif/tlv_irq_ctrl_tb_top.sv
// tlv_irq_ctrl_tb_top: self-checking bench for the interrupt controller.
// assumes tlv_pkg and tlv_core_model are compiled first.
`timescale 1ns/10ps
module tlv_irq_ctrl_tb_top;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, cmp_fall_flags, cmp_rise_flags;
	logic [2:0] hsize;
	logic ext0_flag, ext1_flag, timer0_overflow_set, timer1_overflow_set, uart_rx_flag, uart_tx_flag;
	logic timer2_overflow_flag, timer2_external_flag, serial_periph_flag, twowire_flag, conv_window_flag;
	logic counter_array_overflow_flag, timer3_flag, conv_done_flag, xtal_valid_flag;
	logic [4:0] capture_module_flags;
	logic [3:0] port1_pins, instr_gap;
	logic core_irq_ack, core_return_from_irq, core_instr_done, core_irq_req, core_irq_level;
	logic timer0_overflow_flag, timer1_overflow_flag, en_ack, do_return_from_irq;
	logic [15:0] core_irq_vector;
	logic [21:0] s, pr;
	int miscompares, tests_run, ra, da, w;
	assign hready = hreadyout;
	tlv_irq_ctrl i_tlv_irq_ctrl (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.ext0_flag(ext0_flag), .ext1_flag(ext1_flag), .timer0_overflow_set(timer0_overflow_set),
		.timer1_overflow_set(timer1_overflow_set), .uart_rx_flag(uart_rx_flag), .uart_tx_flag(uart_tx_flag),
		.timer2_overflow_flag(timer2_overflow_flag), .timer2_external_flag(timer2_external_flag),
		.serial_periph_flag(serial_periph_flag), .twowire_flag(twowire_flag), .conv_window_flag(conv_window_flag),
		.counter_array_overflow_flag(counter_array_overflow_flag), .capture_module_flags(capture_module_flags),
		.cmp_fall_flags(cmp_fall_flags), .cmp_rise_flags(cmp_rise_flags), .timer3_flag(timer3_flag),
		.conv_done_flag(conv_done_flag), .xtal_valid_flag(xtal_valid_flag), .port1_pins(port1_pins),
		.core_irq_ack(core_irq_ack), .core_return_from_irq(core_return_from_irq), .core_instr_done(core_instr_done),
		.core_irq_req(core_irq_req), .core_irq_vector(core_irq_vector), .core_irq_level(core_irq_level),
		.timer0_overflow_flag(timer0_overflow_flag), .timer1_overflow_flag(timer1_overflow_flag)
	);
	tlv_core_model i_tlv_core_model (
		.hclk(hclk), .hresetn(hresetn), .core_irq_req(core_irq_req), .en_ack(en_ack), .do_return_from_irq(do_return_from_irq),
		.instr_gap(instr_gap), .core_irq_ack(core_irq_ack), .core_return_from_irq(core_return_from_irq),
		.core_instr_done(core_instr_done)
	);
	// ==========================================================
	// shared tasks
	function automatic logic [31:0] adr(logic [7:0] idx);
		return {22'h00_0000, idx, 2'b00};
	endfunction : adr
	// model: high level first, then lowest order number
	function automatic int win(logic [21:0] p, logic [21:0] h);
		int wh;
		int wl;
		wh = -1;
		wl = -1;
		for (int i = 21; i >= 0; i--) begin
			if (p[i] && h[i]) wh = i;
			if (p[i]) wl = i;
		end
		return (wh >= 0) ? wh : wl;
	endfunction : win
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb
	// paired sources get one flag or the other at random
	task automatic set_src(input logic [21:0] v, input logic [7:0] r);
		ext0_flag <= v[0];
		ext1_flag <= v[2];
		uart_rx_flag <= v[4] & r[0];
		uart_tx_flag <= v[4] & ~r[0];
		timer2_overflow_flag <= v[5] & r[1];
		timer2_external_flag <= v[5] & ~r[1];
		serial_periph_flag <= v[6];
		twowire_flag <= v[7];
		conv_window_flag <= v[8];
		counter_array_overflow_flag <= v[9] & r[2];
		capture_module_flags <= (v[9] & ~r[2]) ? 5'h01 << (r[7:3] % 5) : 5'h00;
		cmp_fall_flags <= {v[12], v[10]};
		cmp_rise_flags <= {v[13], v[11]};
		timer3_flag <= v[14];
		conv_done_flag <= v[15];
		xtal_valid_flag <= v[21];
	endtask : set_src
	task automatic watch(input int n);
		ra = -1;
		da = -1;
		for (int i = 0; i < n; i++) begin
			@(negedge hclk);
			if (da < 0 && core_instr_done === 1'b1) da = i;
			if (core_irq_req === 1'b1) begin
				ra = i;
				break;
			end
		end
	endtask : watch
	task automatic ret();
		@(posedge hclk);
		do_return_from_irq <= 1'b1;
		@(posedge hclk);
		do_return_from_irq <= 1'b0;
		repeat (8) @(posedge hclk);
	endtask : ret
	task automatic end_sim();
		$display("tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim
	// ==========================================================
	// clock, watchdog, sequence
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	initial begin
		repeat (20000) @(posedge hclk);
		miscompares++;
		end_sim();
	end
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{timer0_overflow_set, timer1_overflow_set, en_ack, do_return_from_irq} = '0;
		hsize = 3'h2;
		port1_pins = 4'hf;
		instr_gap = 4'h3;
		set_src(22'h00_0000, 8'h00);
		void'($urandom(32'hb561_5bdb));
		repeat (3) @(posedge hclk);
		chk(core_irq_vector, 32'h0000_0000, "reset vector");
		hresetn <= 1'b1;
		ahb(0, adr(tlv_pkg::IDX_PRIO_A), 0);
		chk(rd, 32'h0000_0000, "prio a reset");
		ahb(0, adr(tlv_pkg::IDX_PRIO_B), 0);
		chk(rd, 32'h0000_0000, "prio b reset");
		// software keeps the reserved bit at zero
		ahb(1, adr(tlv_pkg::IDX_PRIO_B), 32'h0000_00bf);
		ahb(0, adr(tlv_pkg::IDX_PRIO_B), 0);
		chk(rd, 32'h0000_00bf, "prio b reserved bit");
		ahb(0, 32'h0000_0004, 0);
		chk(rd, 32'h0000_0000, "unmapped read");
		chk({hreadyout, hresp}, 32'h0000_0002, "bus response okay");
		ahb(1, adr(tlv_pkg::IDX_BASE_EN), 32'h0000_00bf);
		ahb(1, adr(tlv_pkg::IDX_EXT_EN_A), 32'h0000_00ff);
		ahb(1, adr(tlv_pkg::IDX_EXT_EN_B), 32'h0000_00bf);
		repeat (40) begin
			pr = 22'($urandom) & 22'h2f_ffff;
			ahb(1, adr(tlv_pkg::IDX_BASE_PRIO), {26'h000_0000, pr[5:0]});
			ahb(1, adr(tlv_pkg::IDX_PRIO_A), {24'h00_0000, pr[13:6]});
			ahb(1, adr(tlv_pkg::IDX_PRIO_B), {24'h00_0000, pr[21], 1'b0, pr[19:14]});
			s = 22'($urandom & $urandom) & 22'h20_fff5;
			@(posedge hclk);
			set_src(s, 8'($urandom));
			repeat (3) @(negedge hclk);
			w = win(s, pr);
			chk(core_irq_req, w >= 0, "request");
			if (w >= 0) begin
				chk(core_irq_vector, 32'h0000_0003 + 32'(8 * w), "vector");
				chk(core_irq_level, pr[w], "level");
			end
		end
		set_src(22'h00_0000, 8'h00);
		ahb(1, adr(tlv_pkg::IDX_BASE_PRIO), 32'h0000_0004);
		ahb(1, adr(tlv_pkg::IDX_PRIO_A), 0);
		ahb(1, adr(tlv_pkg::IDX_PRIO_B), 0);
		@(posedge hclk);
		en_ack <= 1'b1;
		ext0_flag <= 1'b1;
		watch(10);
		chk(32'(ra), 32'h0000_0001, "detect latency");
		chk(core_irq_vector, 32'h0000_0003, "low vector");
		repeat (3) @(posedge hclk);
		ext0_flag <= 1'b0;
		ext1_flag <= 1'b1;
		watch(10);
		chk({core_irq_level, core_irq_vector}, 32'h0001_0013, "high preempts low");
		repeat (3) @(posedge hclk);
		ext1_flag <= 1'b0;
		@(posedge hclk);
		ext1_flag <= 1'b1;
		watch(8);
		chk(32'(ra), 32'hffff_ffff, "high routine not preempted");
		// watch from the return on, so the following instruction is seen
		@(posedge hclk);
		do_return_from_irq <= 1'b1;
		@(posedge hclk);
		do_return_from_irq <= 1'b0;
		watch(30);
		// hold drops on the edge after the instruction, then one detect cycle
		chk(32'(ra), 32'(da + 2), "one instruction after return");
		repeat (3) @(posedge hclk);
		ext1_flag <= 1'b0;
		instr_gap <= 4'h0;
		ret();
		ret();
		for (int t = 0; t < 2; t++) begin
			@(posedge hclk);
			{timer1_overflow_set, timer0_overflow_set} <= 2'b01 << t;
			@(posedge hclk);
			{timer1_overflow_set, timer0_overflow_set} <= 2'b00;
			watch(10);
			chk(core_irq_vector, 32'h0000_000b + 32'(16 * t), "timer vector");
			repeat (4) @(negedge hclk);
			chk({timer1_overflow_flag, timer0_overflow_flag}, 0, "flag cleared on vectoring");
			ret();
		end
		en_ack <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			@(posedge hclk);
			port1_pins <= ~(4'h1 << k);
			watch(12);
			chk({core_irq_req, core_irq_vector}, 32'h0001_0083 + 32'(8 * k), "edge source");
			ahb(0, adr(tlv_pkg::IDX_PORT1_FLAGS), 0);
			chk(rd, 32'h0000_0010 << k, "edge flag");
			port1_pins <= 4'hf;
			ahb(1, adr(tlv_pkg::IDX_PORT1_FLAGS), 32'h0000_0010 << k);
			ahb(0, adr(tlv_pkg::IDX_PORT1_FLAGS), 0);
			chk(rd, 32'h0000_0000, "edge flag cleared");
		end
		@(posedge hclk);
		timer1_overflow_set <= 1'b1;
		@(posedge hclk);
		timer1_overflow_set <= 1'b0;
		ahb(0, adr(tlv_pkg::IDX_TIMER_FLAGS), 0);
		chk(rd, 32'h0000_0080, "timer1 flag read");
		ahb(1, adr(tlv_pkg::IDX_TIMER_FLAGS), 32'h0000_0080);
		@(negedge hclk);
		chk(timer1_overflow_flag, 0, "software clear");
		end_sim();
	end
endmodule : tlv_irq_ctrl_tb_top
